// ==== sli_burst.sv ====
// Error class burst generator: class pulses then a long dark gap
module sli_burst (
	input  wire logic       ref_clk,
	input  wire logic       rst,
	input  wire logic       enable,
	input  wire logic       tick,
	input  wire logic [3:0] err_class,
	output logic            red_q
);
	logic [4:0] slot_q;
	logic [4:0] last_slot;
	logic [4:0] slot_nxt;
	logic [3:0] cls;

	// class clamp, out-of-range counts as internal
	always_comb
	begin
		cls = err_class;
		if (err_class < sli_pkg::CLASS_MIN || err_class > sli_pkg::CLASS_MAX)
			cls = sli_pkg::CLASS_MAX;
		last_slot = 5'({cls, 1'b0}) + 5'(sli_pkg::GAP_SLOTS) - 5'h1;
		slot_nxt  = (slot_q >= last_slot) ? 5'h0 : slot_q + 5'h1;
	end

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			slot_q <= 5'h0;
			red_q  <= 1'b0;
		end
		else if (!enable)
		begin
			slot_q <= 5'h0;
			red_q  <= 1'b0;
		end
		else if (tick)
		begin
			slot_q <= slot_nxt;
			red_q  <= !slot_nxt[0] && (slot_nxt < 5'({cls, 1'b0}));
		end
		else if (slot_q == 5'h0 && !red_q)
			red_q <= 1'b1;
	end

	a_burst_slots: assert property (@(posedge ref_clk) disable iff (rst)
		red_q |-> (slot_q[0] == 1'b0) && (slot_q < 5'({cls, 1'b0})))
		else $error("red pulse outside class slots");
endmodule : sli_burst

// ==== sli_lamp_viewer.sv ====
// Operator view of the supply lamp: counts red pulses in each burst
module sli_lamp_viewer #(
	parameter int unsigned HALF = 4
) (
	input  wire logic ref_clk,
	input  wire logic rst,
	input  wire logic red,
	output int        burst_len
);
	timeunit 1ns;
	timeprecision 100ps;
	int   pulses;
	int   dark;
	logic red_d;
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			pulses <= 0;
			dark <= 0;
			red_d <= 1'b0;
			burst_len <= 0;
		end
		else
		begin
			red_d <= red;
			dark <= red ? 0 : dark + 1;
			if (red && !red_d)
				pulses <= pulses + 1;
			if (dark == 3 * HALF && pulses > 0)
			begin
				burst_len <= pulses;
				pulses <= 0;
			end
		end
	end
endmodule : sli_lamp_viewer

// ==== sli_pkg.sv ====
// Constants shared by the status lamp indicator block
package sli_pkg;
	localparam int unsigned CLK_HZ        = 100_000_000;
	localparam int unsigned BLINK_HZ      = 1;
	localparam int unsigned NET_BLINK_S   = 3;
	localparam int unsigned HALF_CYCLES   = CLK_HZ / (2 * BLINK_HZ);
	localparam int unsigned NET_CYCLES    = NET_BLINK_S * CLK_HZ;
	localparam int unsigned GAP_SLOTS     = 6;
	localparam int unsigned NUM_IN        = 20;
	localparam int unsigned NUM_PAIR      = 10;
	localparam int unsigned NUM_OUT       = 8;
	localparam int unsigned NUM_SUPPLY    = 3;
	localparam logic [3:0]  CLASS_MIN     = 4'h2;
	localparam logic [3:0]  CLASS_MAX     = 4'h8;
	localparam logic [3:0]  ADDR_CTRL     = 4'h0;
	localparam logic [3:0]  ADDR_STATUS   = 4'h4;
	localparam int unsigned CTRL_NET_BIT  = 0;
	localparam int unsigned CTRL_START_BIT = 1;
	localparam logic [1:0]  RESP_OKAY     = 2'h0;
	localparam logic [1:0]  RESP_SLVERR   = 2'h2;
	localparam logic        PHASE_RESET   = 1'b0;
	typedef enum logic [1:0] {ST_NO_PROJ, ST_WAIT, ST_RUN} sli_ctrl_state_t;
endpackage : sli_pkg

// ==== sli_timebase.sv ====
// Shared blink timebase: phase toggles every half period, tick marks each toggle
module sli_timebase #(
	parameter int unsigned HALF = sli_pkg::HALF_CYCLES
) (
	input  wire logic ref_clk,
	input  wire logic rst,
	output logic      phase_q,
	output logic      tick_q
);
	logic [31:0] cnt_q;

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			cnt_q   <= 32'h0;
			phase_q <= sli_pkg::PHASE_RESET;
			tick_q  <= 1'b0;
		end
		else if (cnt_q == 32'(HALF - 1))
		begin
			cnt_q   <= 32'h0;
			phase_q <= ~phase_q;
			tick_q  <= 1'b1;
		end
		else
		begin
			cnt_q  <= cnt_q + 32'h1;
			tick_q <= 1'b0;
		end
	end

	a_tick_toggle: assert property (@(posedge ref_clk) disable iff (rst)
		tick_q |-> phase_q != $past(phase_q))
		else $error("phase did not toggle on tick");
endmodule : sli_timebase

// ==== sli_top.sv ====
// Front panel lamp driver with AXI4-Lite control and status registers
module sli_top #(
	parameter int unsigned HALF_CYCLES = sli_pkg::HALF_CYCLES,
	parameter int unsigned NET_CYCLES  = sli_pkg::NET_CYCLES
) (
	input  wire logic                        ref_clk,
	input  wire logic                        rst,
	input  wire logic                        s_axi_awvalid,
	output logic                             s_axi_awready,
	input  wire logic [3:0]                  s_axi_awaddr,
	input  wire logic                        s_axi_wvalid,
	output logic                             s_axi_wready,
	input  wire logic [31:0]                 s_axi_wdata,
	input  wire logic [3:0]                  s_axi_wstrb,
	output logic                             s_axi_bvalid,
	input  wire logic                        s_axi_bready,
	output logic [1:0]                       s_axi_bresp,
	input  wire logic                        s_axi_arvalid,
	output logic                             s_axi_arready,
	input  wire logic [3:0]                  s_axi_araddr,
	output logic                             s_axi_rvalid,
	input  wire logic                        s_axi_rready,
	output logic [31:0]                      s_axi_rdata,
	output logic [1:0]                       s_axi_rresp,
	input  wire logic                        err_active,
	input  wire logic [3:0]                  err_class,
	input  wire logic [sli_pkg::NUM_SUPPLY-1:0] supply_ok,
	input  wire logic                        project_ok,
	input  wire logic                        cfg_verified,
	input  wire logic [sli_pkg::NUM_IN-1:0]  in_level,
	input  wire logic [sli_pkg::NUM_IN-1:0]  in_configured,
	input  wire logic [sli_pkg::NUM_IN-1:0]  in_test_err,
	input  wire logic [sli_pkg::NUM_PAIR-1:0] in_two_channel,
	input  wire logic [sli_pkg::NUM_PAIR-1:0] in_pair_err,
	input  wire logic [sli_pkg::NUM_OUT-1:0] out_on,
	input  wire logic [sli_pkg::NUM_OUT-1:0] out_test_err,
	output logic                             supply_error_lamp_red_q,
	output logic                             supply_error_lamp_green_q,
	output logic                             module_state_lamp_red_q,
	output logic                             module_state_lamp_green_q,
	output logic                             verified_lamp_q,
	output logic                             network_lamp_q,
	output logic [sli_pkg::NUM_IN-1:0]       input_lamp_q,
	output logic [sli_pkg::NUM_OUT-1:0]      output_lamp_q,
	output logic                             outputs_force_off_q,
	output logic                             control_running_q
);

// Overview of operation
// - On an error the supply lamp blinks red in bursts of class pulses.
// - Pulse counts: 2 config, 3 application ... 8 internal.
// - While red error shows, all 24 V outputs are forced off.
// - No error but a supply out of range: supply lamp blinks green 1 Hz.
// - No error and all supplies in range: supply lamp steady green.
// - No project or faulty project: module lamp blinks red 1 Hz.
// - Project adopted awaiting start: green blink; started: steady green.
// - Input, pair or output fault: module lamp alternates red and green.
// - Unverified project: verified lamp blinks 1 Hz, no automatic start.
// - Verified project: verified lamp steady, automatic start after power-on.
// - Connection setup: network lamp blinks green for 3 s.
// - Single input error: lamp blinks with red module blink; unconfigured high input: lamp blinks, module lamp unaffected.
// - Two-channel pair fault: both pair lamps blink 1 Hz in alternation.
// - Input lamp without error is off when input is low.
// - Configured input lamp without error is steady green when input is high.
// - Output lamp blinks green 1 Hz on an output test error.
// - Output lamp without test error is off when output is off.
// - Verified lamp follows the retained verification flag.

	logic                        phase;
	logic                        tick;
	logic                        burst_red;
	logic                        net_req_q;
	logic                        start_req_q;
	logic [31:0]                 net_cnt_q;
	logic                        net_active;
	logic                        auto_pend_q;
	logic                        fault_any;
	logic [sli_pkg::NUM_IN-1:0]  in_lamp_d;
	logic                        wr_go;
	logic                        rd_go;
	logic                        wr_hit;
	logic                        rd_hit;
	sli_pkg::sli_ctrl_state_t    state_q;

	sli_timebase #(
		.HALF (HALF_CYCLES)
	) u_timebase (
		.ref_clk (ref_clk),
		.rst     (rst),
		.phase_q (phase),
		.tick_q  (tick)
	);

	sli_burst u_burst (
		.ref_clk   (ref_clk),
		.rst       (rst),
		.enable    (err_active),
		.tick      (tick),
		.err_class (err_class),
		.red_q     (burst_red)
	);

	// AXI4-Lite write: address and data taken together, one at a time
	assign wr_go  = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && !s_axi_awready;
	assign wr_hit = (s_axi_awaddr == sli_pkg::ADDR_CTRL);
	assign rd_go  = s_axi_arvalid && !s_axi_rvalid && !s_axi_arready;
	assign rd_hit = (s_axi_araddr == sli_pkg::ADDR_CTRL) || (s_axi_araddr == sli_pkg::ADDR_STATUS);

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= sli_pkg::RESP_OKAY;
			net_req_q     <= 1'b0;
			start_req_q   <= 1'b0;
		end
		else
		begin
			s_axi_awready <= wr_go;
			s_axi_wready  <= wr_go;
			net_req_q     <= wr_go && wr_hit && s_axi_wstrb[0]
				&& s_axi_wdata[sli_pkg::CTRL_NET_BIT];
			start_req_q   <= wr_go && wr_hit && s_axi_wstrb[0]
				&& s_axi_wdata[sli_pkg::CTRL_START_BIT];
			if (wr_go)
				s_axi_bresp <= wr_hit ? sli_pkg::RESP_OKAY : sli_pkg::RESP_SLVERR;
			if (s_axi_awready)
				s_axi_bvalid <= 1'b1;
			else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// AXI4-Lite read: status shows block state, control reads zero
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0;
			s_axi_rresp   <= sli_pkg::RESP_OKAY;
		end
		else
		begin
			s_axi_arready <= rd_go;
			if (rd_go)
			begin
				s_axi_rresp  <= rd_hit ? sli_pkg::RESP_OKAY : sli_pkg::RESP_SLVERR;
				s_axi_rdata  <= 32'h0;
				if (s_axi_araddr == sli_pkg::ADDR_STATUS)
					s_axi_rdata <= {22'h0, phase, net_active, control_running_q,
						outputs_force_off_q, state_q, err_active, err_class[2:0]};
			end
			if (s_axi_arready)
				s_axi_rvalid <= 1'b1;
			else if (s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			net_cnt_q <= 32'h0;
		else if (net_req_q)
			net_cnt_q <= 32'(NET_CYCLES);
		else if (net_cnt_q != 32'h0)
			net_cnt_q <= net_cnt_q - 32'h1;
	end
	assign net_active = (net_cnt_q != 32'h0);

	// automatic start only once after power-on and only if verified
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			state_q     <= sli_pkg::ST_NO_PROJ;
			auto_pend_q <= 1'b1;
		end
		else
		begin
			unique case (state_q)
				sli_pkg::ST_NO_PROJ:
				begin
					if (project_ok && !err_active)
					begin
						auto_pend_q <= 1'b0;
						state_q     <= (auto_pend_q && cfg_verified) ? sli_pkg::ST_RUN
							: sli_pkg::ST_WAIT;
					end
				end
				sli_pkg::ST_WAIT:
				begin
					if (!project_ok)
						state_q <= sli_pkg::ST_NO_PROJ;
					else if (start_req_q && !err_active)
						state_q <= sli_pkg::ST_RUN;
				end
				sli_pkg::ST_RUN:
				begin
					if (!project_ok)
						state_q <= sli_pkg::ST_NO_PROJ;
					else if (err_active)
						state_q <= sli_pkg::ST_WAIT;
				end
			endcase
		end
	end

	assign fault_any = (|in_test_err) || (|(in_pair_err & in_two_channel)) || (|out_test_err);

	always_comb
	begin
		in_lamp_d = '0;
		for (int i = 0; i < int'(sli_pkg::NUM_IN); i++)
		begin
			if (in_two_channel[i/2] && (in_pair_err[i/2] || in_test_err[(i/2)*2]
				|| in_test_err[(i/2)*2+1]))
				in_lamp_d[i] = (i % 2 == 0) ? phase : ~phase;
			else if (in_test_err[i] || (!in_configured[i] && in_level[i]))
				in_lamp_d[i] = phase;
			else
				in_lamp_d[i] = in_level[i];
		end
	end

	// supply and error lamp, outputs forced off with red
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			supply_error_lamp_red_q   <= 1'b0;
			supply_error_lamp_green_q <= 1'b0;
			outputs_force_off_q       <= 1'b0;
		end
		else
		begin
			supply_error_lamp_red_q   <= err_active && burst_red;
			outputs_force_off_q       <= err_active;
			supply_error_lamp_green_q <= !err_active && ((&supply_ok) || phase);
		end
	end

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			module_state_lamp_red_q   <= 1'b0;
			module_state_lamp_green_q <= 1'b0;
		end
		else if (fault_any)
		begin
			module_state_lamp_red_q   <= phase;
			module_state_lamp_green_q <= ~phase;
		end
		else
		begin
			module_state_lamp_red_q   <= (state_q == sli_pkg::ST_NO_PROJ) && phase;
			module_state_lamp_green_q <= (state_q == sli_pkg::ST_RUN)
				|| ((state_q == sli_pkg::ST_WAIT) && phase);
		end
	end

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			verified_lamp_q   <= 1'b0;
			network_lamp_q    <= 1'b0;
			control_running_q <= 1'b0;
		end
		else
		begin
			verified_lamp_q   <= cfg_verified || phase;
			network_lamp_q    <= net_active && phase;
			control_running_q <= (state_q == sli_pkg::ST_RUN);
		end
	end

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			input_lamp_q  <= '0;
			output_lamp_q <= '0;
		end
		else
		begin
			input_lamp_q  <= in_lamp_d;
			output_lamp_q <= (out_test_err & {sli_pkg::NUM_OUT{phase}})
				| (~out_test_err & out_on);
		end
	end

	a_force_off_red: assert property (@(posedge ref_clk) disable iff (rst)
		supply_error_lamp_red_q |-> outputs_force_off_q)
		else $error("red error shown while outputs not forced off");
	a_supply_steady: assert property (@(posedge ref_clk) disable iff (rst)
		(!err_active && (&supply_ok)) |=> supply_error_lamp_green_q
			&& !supply_error_lamp_red_q)
		else $error("supply lamp not steady green");
	a_supply_blink: assert property (@(posedge ref_clk) disable iff (rst)
		(!err_active && !(&supply_ok)) |=> supply_error_lamp_green_q == $past(phase))
		else $error("supply lamp not blinking with timebase");
	a_fault_alternate: assert property (@(posedge ref_clk) disable iff (rst)
		fault_any |=> module_state_lamp_red_q != module_state_lamp_green_q)
		else $error("module lamp not alternating on fault");
	a_verified_steady: assert property (@(posedge ref_clk) disable iff (rst)
		cfg_verified [*2] |=> verified_lamp_q)
		else $error("verified lamp dark while flag set");
	a_net_window: assert property (@(posedge ref_clk) disable iff (rst)
		net_req_q |=> net_active [*8])
		else $error("network blink window ended early");
	a_out_lamp_follow: assert property (@(posedge ref_clk) disable iff (rst)
		1'b1 |=> ((output_lamp_q ^ $past(out_on)) & ~$past(out_test_err)) == 8'h00)
		else $error("output lamp does not follow output state");
	a_no_auto_start: assert property (@(posedge ref_clk) disable iff (rst)
		(state_q == sli_pkg::ST_NO_PROJ && !cfg_verified) |=> state_q != sli_pkg::ST_RUN)
		else $error("unverified project started automatically");
	for (genvar p = 0; p < int'(sli_pkg::NUM_PAIR); p++)
	begin : g_pair_chk
		a_pair_alternate: assert property (@(posedge ref_clk) disable iff (rst)
			(in_two_channel[p] && in_pair_err[p]) |=> ^input_lamp_q[2*p +: 2])
			else $error("pair lamps not alternating");
	end
endmodule : sli_top

// ==== tb_top.sv ====
// Self-checking bench for the front panel lamp driver
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int unsigned HALF = 4;
	localparam int unsigned NETC = 40;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb, err_class;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [1:0] s_axi_bresp, s_axi_rresp, resp;
	logic err_active, project_ok, cfg_verified, outputs_force_off_q, control_running_q;
	logic supply_error_lamp_red_q, supply_error_lamp_green_q, verified_lamp_q;
	logic module_state_lamp_red_q, module_state_lamp_green_q, network_lamp_q;
	logic [sli_pkg::NUM_SUPPLY-1:0] supply_ok;
	logic [sli_pkg::NUM_IN-1:0] in_level, in_configured, in_test_err, input_lamp_q;
	logic [sli_pkg::NUM_PAIR-1:0] in_two_channel, in_pair_err;
	logic [sli_pkg::NUM_OUT-1:0] out_on, out_test_err, output_lamp_q;
	logic [33:0] lamps;
	int bad_count = 0;
	int checks = 0;
	int hi[34];
	int same_ms, same_pair, diff_in, diff_ms, burst_len;

	always #5 ref_clk = ~ref_clk;
	assign lamps = {output_lamp_q, input_lamp_q, network_lamp_q, verified_lamp_q,
		module_state_lamp_green_q, module_state_lamp_red_q,
		supply_error_lamp_green_q, supply_error_lamp_red_q};

	sli_top #(.HALF_CYCLES(HALF), .NET_CYCLES(NETC)) DUT (
		.ref_clk(ref_clk), .rst(rst),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .err_active(err_active), .err_class(err_class),
		.supply_ok(supply_ok), .project_ok(project_ok), .cfg_verified(cfg_verified),
		.in_level(in_level), .in_configured(in_configured), .in_test_err(in_test_err),
		.in_two_channel(in_two_channel), .in_pair_err(in_pair_err),
		.out_on(out_on), .out_test_err(out_test_err),
		.supply_error_lamp_red_q(supply_error_lamp_red_q),
		.supply_error_lamp_green_q(supply_error_lamp_green_q),
		.module_state_lamp_red_q(module_state_lamp_red_q),
		.module_state_lamp_green_q(module_state_lamp_green_q),
		.verified_lamp_q(verified_lamp_q), .network_lamp_q(network_lamp_q),
		.input_lamp_q(input_lamp_q), .output_lamp_q(output_lamp_q),
		.outputs_force_off_q(outputs_force_off_q), .control_running_q(control_running_q)
	);
	sli_lamp_viewer #(.HALF(HALF)) viewer (.ref_clk(ref_clk), .rst(rst),
		.red(supply_error_lamp_red_q), .burst_len(burst_len));

	task close_out;
		$display("checks=%0d bad_count=%0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : close_out

	task chk_val(input logic [63:0] got, input logic [63:0] exp);
		checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_val

	task chk_cnt(input int got, input int exp);
		checks++;
		if (got != exp)
		begin
			bad_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_cnt

	task axi_wr(input logic [3:0] a, input logic [31:0] d);
		int n;
		@(posedge ref_clk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		n = 0;
		do
		begin
			@(posedge ref_clk);
			if (s_axi_awready === 1'b1)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1)
				s_axi_wvalid <= 1'b0;
			n++;
		end while (s_axi_bvalid !== 1'b1 && n < 50);
		resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
		if (n >= 50)
		begin
			bad_count++;
			close_out();
		end
	endtask : axi_wr

	task axi_rd(input logic [3:0] a);
		int n;
		@(posedge ref_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		n = 0;
		do
		begin
			@(posedge ref_clk);
			if (s_axi_arready === 1'b1)
				s_axi_arvalid <= 1'b0;
			n++;
		end while (s_axi_rvalid !== 1'b1 && n < 50);
		rd = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'b0;
		if (n >= 50)
		begin
			bad_count++;
			close_out();
		end
	endtask : axi_rd

	// Counts lit cycles of every lamp over one full blink period
	task sample;
		same_ms = 0;
		same_pair = 0;
		diff_in = 0;
		diff_ms = 0;
		foreach (hi[i])
			hi[i] = 0;
		repeat (3) @(posedge ref_clk);
		repeat (2 * HALF)
		begin
			@(negedge ref_clk);
			foreach (hi[i])
				hi[i] += (lamps[i] === 1'b1);
			same_ms += (lamps[2] === lamps[3]);
			same_pair += (lamps[10] === lamps[11]);
			diff_in += (lamps[8] !== lamps[9]);
			diff_ms += (lamps[2] !== lamps[8]);
		end
	endtask : sample

	task do_reset;
		if (rst !== 1'b1)
			@(posedge ref_clk);
		rst <= 1'b1;
		repeat (16) @(posedge ref_clk);
		chk_val(lamps, 64'h0);
		rst <= 1'b0;
	endtask : do_reset

	initial
	begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 40'h0;
		s_axi_wstrb = 4'hF;
		{err_active, err_class, project_ok, in_level, in_test_err} = 46'h0;
		{in_two_channel, in_pair_err, out_on, out_test_err} = 36'h0;
		in_configured = 20'hFFFFF;
		supply_ok = 3'h7;
		cfg_verified = 1'b1;
		do_reset();
		sample();
		chk_cnt(hi[1], 8);
		chk_cnt(hi[0], 0);
		chk_cnt(hi[2], 4);
		chk_cnt(hi[4], 8);
		@(posedge ref_clk);
		project_ok <= 1'b1;
		supply_ok <= 3'h5;
		sample();
		chk_cnt(hi[1], 4);
		chk_cnt(hi[3], 8);
		chk_val(control_running_q, 64'h1);
		@(posedge ref_clk);
		in_configured <= 20'hFFFF7;
		in_level <= 20'h00009;
		in_test_err <= 20'h00004;
		in_two_channel <= 10'h004;
		in_pair_err <= 10'h004;
		out_on <= 8'h01;
		out_test_err <= 8'h02;
		sample();
		chk_cnt(hi[6], 8);
		chk_cnt(hi[7], 0);
		chk_cnt(hi[8], 4);
		chk_cnt(hi[9], 4);
		chk_cnt(diff_in, 0);
		chk_cnt(diff_ms, 0);
		chk_cnt(hi[10], 4);
		chk_cnt(same_pair, 0);
		chk_cnt(hi[2], 4);
		chk_cnt(same_ms, 0);
		chk_cnt(hi[26], 8);
		chk_cnt(hi[27], 4);
		chk_cnt(hi[28], 0);
		@(posedge ref_clk);
		{in_test_err, in_pair_err, out_test_err} <= 38'h0;
		cfg_verified <= 1'b0;
		supply_ok <= 3'h7;
		axi_wr(sli_pkg::ADDR_CTRL, 32'h1);
		chk_val(resp, sli_pkg::RESP_OKAY);
		sample();
		chk_cnt(hi[4], 4);
		chk_cnt(hi[5], 4);
		repeat (NETC) @(posedge ref_clk);
		sample();
		chk_cnt(hi[5], 0);
		do_reset();
		sample();
		chk_val(control_running_q, 64'h0);
		chk_cnt(hi[3], 4);
		axi_wr(sli_pkg::ADDR_CTRL, 32'h2);
		repeat (3) @(posedge ref_clk);
		chk_val(control_running_q, 64'h1);
		for (int c = 2; c <= 9; c++)
		begin
			@(posedge ref_clk);
			err_class <= (c == 9) ? 4'hF : 4'(c);
			err_active <= 1'b1;
			repeat (200) @(posedge ref_clk);
			chk_cnt(burst_len, (c == 9) ? 8 : c);
			chk_val(outputs_force_off_q, 64'h1);
			chk_val(supply_error_lamp_green_q, 64'h0);
			if (c < 9)
			begin
				axi_rd(sli_pkg::ADDR_STATUS);
				chk_val(rd & 32'h4F, 32'h48 | (c & 7));
			end
			@(posedge ref_clk);
			err_active <= 1'b0;
			repeat (20) @(posedge ref_clk);
			chk_val(outputs_force_off_q, 64'h0);
		end
		axi_rd(4'h8);
		chk_val({resp, rd}, {sli_pkg::RESP_SLVERR, 32'h0});
		axi_wr(sli_pkg::ADDR_STATUS, 32'h3);
		chk_val(resp, sli_pkg::RESP_SLVERR);
		repeat (3) @(posedge ref_clk);
		chk_val(control_running_q, 64'h0);
		close_out();
	end
endmodule : tb_top
